// File: hw/stw_pkg.sv
// constants and types shared by the toggle supervisor design
package stw_pkg;

    localparam int CLK_HZ             = 10_000_000;
    localparam int TOGGLE_TIMEOUT_MS  = 327;
    localparam int TOGGLE_TOL_MS      = 16;
    // least time: rounds down, exact at this rate
    localparam int TOGGLE_TIMEOUT_CYC = TOGGLE_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WD_CNT_W           = 22;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    localparam logic [ADDR_W-1:0] OFS_CFG      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IDX      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATE    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h10;

    localparam int CFG_LOCK       = 0;
    localparam int CFG_WD_ACT     = 1;
    localparam int CFG_PORT_GATED = 2;
    localparam int CFG_EXT4       = 3;
    localparam int CFG_EXT_ADDR   = 4;
    localparam int CFG_PROF_LSB   = 8;
    localparam int PROF_W         = 4;
    localparam int CFG_W          = 12;
    localparam logic [CFG_W-1:0] CFG_RST = 12'h000;

    localparam int ID_W         = 4;
    localparam int IDX_USER_LSB = 0;
    localparam int IDX_LOCK_LSB = 4;
    localparam int IDX_W        = 8;
    localparam int ID_AB_BIT    = 3;
    localparam logic [IDX_W-1:0] IDX_RST = 8'h00;

    localparam int STS_DX_DIS = 0;
    localparam int STS_WD_ON  = 1;
    localparam int STS_WD_RUN = 2;
    localparam int STS_NIB    = 3;
    localparam int STS_W      = 4;

    localparam int INT_TRIP   = 0;
    localparam int INT_REJECT = 1;
    localparam int INT_W      = 2;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [ID_W-1:0] MASK_ALL = 4'hF;
    localparam logic [ID_W-1:0] MASK_LOW = 4'h7;

    typedef enum logic {
        WD_OFF,
        WD_ON
    } stw_wd_state_t;

endpackage

// File: hw/stw_wd_if.sv
// link between supervisor control and the toggle timer
`timescale 1ns/100ps
interface stw_wd_if;
    logic run;
    logic restart;
    logic expired;
    modport ctrl  (output run, output restart, input expired);
    modport timer (input run, input restart, output expired);
endinterface

// File: hw/stw_toggle_timer.sv
// timeout counter of the toggle watchdog
`timescale 1ns/100ps
module stw_toggle_timer
    import stw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = TOGGLE_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    stw_wd_if.timer  wd
);
    localparam logic [WD_CNT_W-1:0] LAST = WD_CNT_W'(TIMEOUT_CYC - 1);

    logic [WD_CNT_W-1:0] count_ff;
    logic                expired_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count_ff <= '0;
        else if (!wd.run || wd.restart || count_ff == LAST)
            count_ff <= '0;
        else
            count_ff <= count_ff + 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            expired_ff <= 1'b0;
        else
            expired_ff <= wd.run && !wd.restart && count_ff == LAST;
    end

    assign wd.expired = expired_ff;

    a_expire_single: assert property (@(posedge clk) disable iff (!reset_n)
        wd.expired |=> !wd.expired)
        else $error("timer expiry lasted more than one cycle");

endmodule // stw_toggle_timer

// File: hw/stw_supervisor.sv
// toggle watchdog and first id extension protection with axi4-lite registers
// Behaviour
// - in extended four-in/four-out mode each output word comes as two nibbles, and the nibble select bit is supervised.
// - the watchdog is enabled by the first data exchange after init, only with a nonzero slave address.
// - any reset and every delete address request disable the watchdog.
// - it runs only in the four-in/four-out profile with the mode bit set and either activation flag condition true.
// - no nibble toggle for the timeout makes an unconditioned reset that also sets the exchange disable flag.
// - after a watchdog reset data exchange stays blocked until a write parameter request arrives.
// - with the lock flag set the id extension answer comes from the locked copy.
// - locked and in extended addressing, answer bit 3 comes from the user copy.
// - locked, a write whose protected bits differ is dropped with no eeprom write and no answer.
// - unlocked, the whole answer comes from the user copy.
// - unlocked, every write is answered and starts an eeprom write.
`timescale 1ns/100ps
module stw_supervisor
    import stw_pkg::*;
#(
    parameter int unsigned WD_TIMEOUT_CYC  = TOGGLE_TIMEOUT_CYC,
    parameter logic [PROF_W-1:0] FOUR_IO_PROFILE = 4'h7 // value arbitrary
)
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [STRB_W-1:0] s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [4:0]        slave_addr,
    input  wire logic              dx_req,
    input  wire logic              nibble_select_bit,
    input  wire logic              delete_addr_req,
    input  wire logic              write_param_req,
    input  wire logic              read_id1_req,
    input  wire logic              write_id1_req,
    input  wire logic [ID_W-1:0]   write_id1_data,
    input  wire logic              parameter_port_bit_zero,
    output logic                   wd_reset,
    output logic                   data_exchange_disable,
    output logic [ID_W-1:0]        id1_answer,
    output logic                   id1_answer_valid,
    output logic                   id1_write_ack,
    output logic                   eeprom_write,
    output logic [ID_W-1:0]        eeprom_data,
    output logic                   irq
);

    function automatic logic [DATA_W-1:0] apply_strb(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int b = 0; b < STRB_W; b++)
            if (strb[b])
                r[b*8 +: 8] = new_w[b*8 +: 8];
        return r;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return a == OFS_CFG || a == OFS_IDX || a == OFS_STATE
            || a == OFS_INT_STAT || a == OFS_INT_MASK;
    endfunction

    // selector bit stays user owned in extended addressing
    function automatic logic [ID_W-1:0] prot_mask(input logic ext);
        return ext ? MASK_LOW : MASK_ALL;
    endfunction

    stw_wd_if wd ();

    logic                p0_meta_ff;
    logic                p0_sync_ff;
    logic [CFG_W-1:0]    cfg_ff;
    logic [IDX_W-1:0]    idx_ff;
    logic [INT_W-1:0]    int_stat_ff;
    logic [INT_W-1:0]    int_mask_ff;
    stw_wd_state_t       wd_state_ff;
    logic                last_nib_ff;
    logic                dx_disable_ff;
    logic [ID_W-1:0]     id1_answer_ff;
    logic                id1_valid_ff;
    logic                id1_ack_ff;
    logic                eeprom_wr_ff;
    logic [ID_W-1:0]     eeprom_data_ff;
    logic                aw_hold_ff;
    logic [ADDR_W-1:0]   awaddr_ff;
    logic                w_hold_ff;
    logic [DATA_W-1:0]   wdata_ff;
    logic [STRB_W-1:0]   wstrb_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                rvalid_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic [1:0]          rresp_ff;

    logic                do_write;
    logic [DATA_W-1:0]   rd_word;
    logic [DATA_W-1:0]   mrg_cfg;
    logic [DATA_W-1:0]   mrg_idx;
    logic [DATA_W-1:0]   mrg_mask;
    logic [INT_W-1:0]    int_evt;
    logic [INT_W-1:0]    w1c;
    logic                lock;
    logic                ext_addr;
    logic [ID_W-1:0]     user_id;
    logic [ID_W-1:0]     locked_id;
    logic [ID_W-1:0]     pmask;
    logic                id_accept;
    logic                wd_cond;
    logic                wd_toggle;
    stw_wd_state_t       nxt_wd_state;

    // a pin: two flops before any use
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            p0_meta_ff <= 1'b0;
            p0_sync_ff <= 1'b0;
        end
        else
        begin
            p0_meta_ff <= parameter_port_bit_zero;
            p0_sync_ff <= p0_meta_ff;
        end
    end

    assign lock      = cfg_ff[CFG_LOCK];
    assign ext_addr  = cfg_ff[CFG_EXT_ADDR];
    assign user_id   = idx_ff[IDX_USER_LSB +: ID_W];
    assign locked_id = idx_ff[IDX_LOCK_LSB +: ID_W];
    assign pmask     = prot_mask(ext_addr);

    assign wd_cond = cfg_ff[CFG_PROF_LSB +: PROF_W] == FOUR_IO_PROFILE
                  && cfg_ff[CFG_EXT4]
                  && (cfg_ff[CFG_WD_ACT]
                      || (cfg_ff[CFG_PORT_GATED] && p0_sync_ff));

    assign wd_toggle = dx_req && nibble_select_bit != last_nib_ff;

    assign wd.run     = wd_state_ff == WD_ON && wd_cond;
    assign wd.restart = wd_toggle;

    stw_toggle_timer #(
        .TIMEOUT_CYC (WD_TIMEOUT_CYC)
    ) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .wd      (wd.timer)
    );

    always_comb
    begin
        nxt_wd_state = wd_state_ff;
        case (wd_state_ff)
            WD_OFF:
                if (dx_req && slave_addr != '0 && !delete_addr_req)
                    nxt_wd_state = WD_ON;
            WD_ON:
                if (delete_addr_req || wd.expired)
                    nxt_wd_state = WD_OFF;
            default:
                nxt_wd_state = WD_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wd_state_ff <= WD_OFF;
        else
            wd_state_ff <= nxt_wd_state;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            last_nib_ff <= 1'b0;
        else if (dx_req)
            last_nib_ff <= nibble_select_bit;
    end

    // set wins over the clearing request in the same cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dx_disable_ff <= 1'b0;
        else if (wd.expired)
            dx_disable_ff <= 1'b1;
        else if (write_param_req)
            dx_disable_ff <= 1'b0;
    end

    assign wd_reset              = wd.expired;
    assign data_exchange_disable = dx_disable_ff;

    // compare only the protected part; bit 3 is free in extended mode
    assign id_accept = !lock
                    || (write_id1_data & pmask) == (locked_id & pmask);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            id1_answer_ff <= '0;
            id1_valid_ff  <= 1'b0;
        end
        else
        begin
            id1_valid_ff <= read_id1_req;
            if (read_id1_req)
                id1_answer_ff <= lock ? ((locked_id & pmask) | (user_id & ~pmask))
                                      : user_id;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            id1_ack_ff     <= 1'b0;
            eeprom_wr_ff   <= 1'b0;
            eeprom_data_ff <= '0;
        end
        else
        begin
            id1_ack_ff   <= write_id1_req && id_accept;
            eeprom_wr_ff <= write_id1_req && id_accept;
            if (write_id1_req && id_accept)
                eeprom_data_ff <= write_id1_data;
        end
    end

    assign id1_answer       = id1_answer_ff;
    assign id1_answer_valid = id1_valid_ff;
    assign id1_write_ack    = id1_ack_ff;
    assign eeprom_write     = eeprom_wr_ff;
    assign eeprom_data      = eeprom_data_ff;

    // bus write: address and data taken in either order
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign do_write      = aw_hold_ff && w_hold_ff && !bvalid_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_hold_ff  <= 1'b0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            else if (do_write)
                aw_hold_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            else if (do_write)
                w_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= addr_known(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    assign mrg_cfg  = apply_strb(DATA_W'(cfg_ff), wdata_ff, wstrb_ff);
    assign mrg_idx  = apply_strb(DATA_W'(idx_ff), wdata_ff, wstrb_ff);
    assign mrg_mask = apply_strb(DATA_W'(int_mask_ff), wdata_ff, wstrb_ff);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_ff <= CFG_RST;
        else if (do_write && awaddr_ff == OFS_CFG)
            cfg_ff <= mrg_cfg[CFG_W-1:0];
    end

    // an accepted bus request beats a software write to the user copy
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            idx_ff <= IDX_RST;
        else if (write_id1_req && id_accept)
            idx_ff[IDX_USER_LSB +: ID_W] <= write_id1_data;
        else if (do_write && awaddr_ff == OFS_IDX)
            idx_ff <= mrg_idx[IDX_W-1:0];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            int_mask_ff <= INT_RST;
        else if (do_write && awaddr_ff == OFS_INT_MASK)
            int_mask_ff <= mrg_mask[INT_W-1:0];
    end

    always_comb
    begin
        int_evt             = '0;
        int_evt[INT_TRIP]   = wd.expired;
        int_evt[INT_REJECT] = write_id1_req && !id_accept;
    end

    assign w1c = (do_write && awaddr_ff == OFS_INT_STAT && wstrb_ff[0])
               ? wdata_ff[INT_W-1:0] : '0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            int_stat_ff <= INT_RST;
        else
            int_stat_ff <= (int_stat_ff & ~w1c) | int_evt;
    end

    assign irq = |(int_stat_ff & int_mask_ff);

    always_comb
    begin
        rd_word = '0;
        if (s_axi_araddr == OFS_CFG)
            rd_word = DATA_W'(cfg_ff);
        else if (s_axi_araddr == OFS_IDX)
            rd_word = DATA_W'(idx_ff);
        else if (s_axi_araddr == OFS_STATE)
        begin
            rd_word[STS_DX_DIS] = dx_disable_ff;
            rd_word[STS_WD_ON]  = wd_state_ff == WD_ON;
            rd_word[STS_WD_RUN] = wd.run;
            rd_word[STS_NIB]    = last_nib_ff;
        end
        else if (s_axi_araddr == OFS_INT_STAT)
            rd_word = DATA_W'(int_stat_ff);
        else if (s_axi_araddr == OFS_INT_MASK)
            rd_word = DATA_W'(int_mask_ff);
    end

    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_toggle_seen;
        wd_state_ff == WD_ON && wd_toggle;
    endsequence

    sequence s_trip_aftermath;
        wd_reset ##1 (dx_disable_ff && wd_state_ff == WD_OFF);
    endsequence

    a_toggle_restarts: assert property (s_toggle_seen |=> !wd.expired [*2])
        else $error("watchdog expired right after a nibble toggle");
    a_enable_addr_zero: assert property (
        (wd_state_ff == WD_OFF && slave_addr == '0) |=> wd_state_ff == WD_OFF)
        else $error("watchdog enabled at slave address zero");
    a_delete_disables: assert property (delete_addr_req |=> wd_state_ff == WD_OFF)
        else $error("delete address left watchdog enabled");
    a_inactive_no_trip: assert property (!wd.run |=> !wd_reset)
        else $error("watchdog reset while not active");
    a_trip_effects: assert property (wd.expired |-> s_trip_aftermath)
        else $error("watchdog trip did not block exchange and disable itself");
    a_block_held: assert property (
        (dx_disable_ff && !write_param_req) |=> dx_disable_ff)
        else $error("exchange unblocked without write parameter");
    a_answer_locked: assert property (
        (read_id1_req && lock && !ext_addr) |=> id1_answer_valid && id1_answer == $past(locked_id))
        else $error("locked answer not taken from locked copy");
    a_answer_ab_bit: assert property (
        (read_id1_req && lock && ext_addr)
        |=> id1_answer[ID_AB_BIT] == $past(user_id[ID_AB_BIT]))
        else $error("selector bit not taken from user copy");
    a_reject_silent: assert property (
        (write_id1_req && lock && !ext_addr && write_id1_data != locked_id)
        |=> !eeprom_write && !id1_write_ack && int_stat_ff[INT_REJECT])
        else $error("mismatching locked write was processed");
    a_ext_write_ok: assert property (
        (write_id1_req && lock && ext_addr
         && write_id1_data[ID_AB_BIT-1:0] == locked_id[ID_AB_BIT-1:0])
        |=> eeprom_write && eeprom_data == $past(write_id1_data))
        else $error("extended locked write with matching low bits refused");
    a_answer_open: assert property (
        (read_id1_req && !lock) |=> id1_answer == $past(user_id))
        else $error("unlocked answer not from user copy");
    a_write_open: assert property (
        (write_id1_req && !lock)
        |=> (eeprom_write && id1_write_ack) ##1 (!eeprom_write || $past(write_id1_req)))
        else $error("unlocked write not answered");

endmodule // stw_supervisor

// File: sim/stw_master_model.sv
// bus master model issuing decoded slave requests
`timescale 1ns/100ps
module stw_master_model
    import stw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [ID_W-1:0] id1_answer,
    output logic                 dx_req,
    output logic                 nibble_select_bit,
    output logic                 delete_addr_req,
    output logic                 write_param_req,
    output logic                 read_id1_req,
    output logic                 write_id1_req,
    output logic [ID_W-1:0]      write_id1_data
);
    initial
    begin
        {dx_req, nibble_select_bit, delete_addr_req, write_param_req} = '0;
        {read_id1_req, write_id1_req, write_id1_data} = '0;
    end
    // kind: 0 exchange, 1 delete, 2 write param, 3 read id, 4 write id
    task automatic req(input int kind, input logic [ID_W-1:0] d);
        @(posedge clk);
        dx_req <= (kind == 0);
        delete_addr_req <= (kind == 1);
        write_param_req <= (kind == 2);
        read_id1_req <= (kind == 3);
        write_id1_req <= (kind == 4);
        nibble_select_bit <= d[0];
        write_id1_data <= d;
        @(posedge clk);
        {dx_req, delete_addr_req, write_param_req, read_id1_req, write_id1_req} <= '0;
        // no stale data left on the lines
        write_id1_data <= ~d;
        #1;
    endtask
    task automatic word(input int n);
        for (int i = 0; i < n; i++)
            req(0, ID_W'(i));
    endtask
    // selector change keeps the protected bits
    task automatic set_ab(input logic b);
        req(3, 4'h0);
        req(4, {b, id1_answer[2:0]});
    endtask
endmodule // stw_master_model

// File: sim/stw_supervisor_bench.sv
// self-checking bench of the toggle supervisor
`timescale 1ns/100ps
module stw_supervisor_bench
    import stw_pkg::*;
;
    localparam int WD = 20;
    logic              clk, reset_n, awvalid, wvalid, bready, arvalid, rready, pin0;
    logic              awready, wready, bvalid, arready, rvalid, wd_reset, dx_dis;
    logic              ans_v, wack, ee_w, irq, dx, nib, del, wpar, rid, wid;
    logic [1:0]        bresp, rresp, rr;
    logic [4:0]        saddr;
    logic [ID_W-1:0]   ans, ee_d, wdat;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [STRB_W-1:0] strb;
    logic [DATA_W-1:0] wdata, rdata, rd;
    int                bad_count, checks_done, cyc, trips;

    stw_supervisor #(.WD_TIMEOUT_CYC(WD)) dut (.clk(clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slave_addr(saddr),
        .dx_req(dx), .nibble_select_bit(nib), .delete_addr_req(del),
        .write_param_req(wpar), .read_id1_req(rid), .write_id1_req(wid),
        .write_id1_data(wdat), .parameter_port_bit_zero(pin0), .wd_reset(wd_reset),
        .data_exchange_disable(dx_dis), .id1_answer(ans), .id1_answer_valid(ans_v),
        .id1_write_ack(wack), .eeprom_write(ee_w), .eeprom_data(ee_d), .irq(irq));
    stw_master_model m (.clk(clk), .id1_answer(ans), .dx_req(dx),
        .nibble_select_bit(nib), .delete_addr_req(del), .write_param_req(wpar),
        .read_id1_req(rid), .write_id1_req(wid), .write_id1_data(wdat));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        trips += (wd_reset === 1'b1);
        // whole run is well under this many cycles
        if (cyc == 6000)
        begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_regs;
        axr(OFS_CFG);
        chk("cfg", rd, 32'h0000_0000);
        axr(8'h14);
        chk("rdata", rd, 32'h0000_0000);
        chk("rresp", rr, RESP_SLVERR);
        axw(8'h20, 32'h0000_0001);
        chk("bresp", rr, RESP_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_id;
        axw(OFS_INT_MASK, 32'h0000_0003);
        m.req(4, 4'h5);
        chk("ack", {wack, ee_w, ee_d}, 6'h35);
        m.req(3, 4'h0);
        chk("ans", {ans_v, ans}, 5'h15);
        axw(OFS_IDX, 32'h0000_003D);
        axw(OFS_CFG, 32'h0000_0001);
        m.req(3, 4'h0);
        chk("ans", ans, 4'h3);
        // differs in bit 3 only, still refused outside extended mode
        m.req(4, 4'hB);
        chk("rej", {wack, ee_w, irq}, 3'b001);
        axw(OFS_INT_STAT, 32'h0000_0002);
        chk("irq", irq, 1'b0);
        axw(OFS_CFG, 32'h0000_0011);
        m.set_ab(1'b0);
        chk("ab", {wack, ee_w, ee_d}, 6'h33);
        m.req(3, 4'h0);
        chk("ans", ans, 4'h3);
        axw(OFS_IDX, 32'h0000_003D);
        m.req(3, 4'h0);
        chk("ans", ans, 4'hB);
        m.req(4, 4'h9);
        chk("rej", {wack, ee_w}, 2'b00);
        // no byte lane 0 means no clear; the reject flag must survive
        strb <= 4'h0;
        axw(OFS_INT_STAT, 32'h0000_0002);
        chk("keep", irq, 1'b1);
        strb <= 4'hF;
        axw(OFS_INT_STAT, 32'h0000_0002);
        chk("irq", irq, 1'b0);
        $display("test id done");
    endtask
    task automatic no_tog(input string n, input int t); // one enable, then silence
        m.word(1);
        idle(2 * WD);
        chk(n, trips, t);
    endtask
    task automatic t_wd;
        axw(OFS_CFG, 32'h0000_070A);
        no_tog("addr0", 0);
        saddr <= 5'h01;
        m.word(20);
        idle(WD - 3);
        chk("toggling", trips, 0);
        idle(7);
        chk("trip", {trips[1:0], dx_dis}, 3'b011);
        axr(OFS_INT_STAT);
        chk("stat", rd, 32'h0000_0001);
        m.word(2);
        chk("dis", dx_dis, 1'b1);
        m.req(2, 4'h0);
        chk("dis", dx_dis, 1'b0);
        m.word(1);
        m.req(1, 4'h0);
        idle(2 * WD);
        chk("del", trips, 1);
        axw(OFS_CFG, 32'h0000_060A);
        no_tog("prof", 1);
        axw(OFS_CFG, 32'h0000_070C);
        no_tog("pin lo", 1);
        pin0 <= 1'b1;
        no_tog("pin hi", 2);
        m.word(1);
        reset_n <= 1'b0;
        idle(2);
        reset_n <= 1'b1;
        // re-arm the run conditions so only the cleared enable keeps it quiet
        axw(OFS_CFG, 32'h0000_070C);
        idle(2 * WD);
        chk("rst", trips, 2);
        axr(OFS_STATE);
        chk("state", rd, 32'h0000_0000);
        $display("test watchdog done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready, pin0} = '0;
        {awaddr, araddr, wdata, saddr} = '0;
        strb = 4'hF;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_id();
        t_wd();
        close_out();
    end
endmodule // stw_supervisor_bench
